// >>> rtl/adcs_consts.vh
// constants for the converter input select and sequencer block
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH
// register word byte addresses
`define ADCS_ADDR_CTRL0 4'h0
`define ADCS_ADDR_CTRL1 4'h1
`define ADCS_ADDR_CTRL2 4'h2
`define ADCS_ADDR_RES_HI 4'h3
`define ADCS_ADDR_RES_LO 4'h4
`define ADCS_ADDR_PINSEL 4'h5
`define ADCS_ADDR_INTC 4'h6
// ctrl0 fields
`define ADCS_C0_START 7
`define ADCS_C0_BUSY 6
`define ADCS_C0_PWR 5
`define ADCS_C0_FMT 4
`define ADCS_C0_CS_LSB 0
// ctrl1 fields
`define ADCS_C1_SRC_LSB 4
`define ADCS_C1_DIV_LSB 0
// ctrl2 fields
`define ADCS_C2_AMPLIFIER_INPUT_SELECT 2
`define ADCS_C2_VRS_LSB 0
// interrupt control fields
`define ADCS_IC_GIE 0
`define ADCS_IC_AIE 1
`define ADCS_IC_FLAG 2
// conversion timing, in converter clocks
`define ADCS_SAMPLE_CLKS 4
`define ADCS_CONV_CLKS 12
// analog mux route codes
`define ADCS_RT_EXT 3'h0
`define ADCS_RT_AVDD 3'h1
`define ADCS_RT_PGA 3'h2
`define ADCS_RT_PROX0 3'h3
`define ADCS_RT_PROX1 3'h4
`define ADCS_RT_GND 3'h5
`define ADCS_RT_FLOAT 3'h6
// reset values
`define ADCS_RST_CTRL1 8'h00
`endif

// >>> rtl/adcs_result_mem.v
// result byte pair store with registered read port
`timescale 1ns/1ps
module adcs_result_mem #(
	parameter DW = 8
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// write side
	input wire wr_en,
	input wire [DW-1:0] wr_hi,
	input wire [DW-1:0] wr_lo,
	// read side
	input wire rd_sel_hi,
	output reg [DW-1:0] rd_data_q
);
	reg [DW-1:0] mem_q [0:1];

	// two words, read data registered
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mem_q[0] <= {DW{1'b0}};
			mem_q[1] <= {DW{1'b0}};
			rd_data_q <= {DW{1'b0}};
		end else begin
			if (wr_en) begin
				mem_q[1] <= wr_hi;
				mem_q[0] <= wr_lo;
			end
			rd_data_q <= rd_sel_hi ? mem_q[1] : mem_q[0];
		end
	end
endmodule // adcs_result_mem

// >>> rtl/adcs_top.v
// converter input selection, pin override and conversion sequencer
// Function
// - analog pin assignment disables every other function on that pin
// - pull-up is cut while the pin is an analog input
// - analog pin selection overrides the port direction register
// - source codes 0000, 0100, 1100-1111 take an external channel
// - channel 0-7 picks a pin; 8-15 leaves the input floating
// - codes 0001-0011 route supply at ratio 1, 1/2, 1/4
// - codes 0101-0111 route amplifier output at ratio 1, 1/2, 1/4
// - code 1000 routes proximity stage 0, 1001 stage 1
// - reserved codes 1010-1011 ground the converter input
// - an internal source switches the external channel off
// - sample 4 converter clocks then convert 12, 16 in all
// - start bit low-high-low begins a conversion
// - busy high during conversion, cleared at end with result valid
// - result layout follows the format bit
// - completion sets the flag; interrupt when both enables set
// - divider code 000 no division, 111 divide by 128
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "adcs_consts.vh"
module adcs_top #(
	parameter NPIN = 8,
	parameter RW = 12
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// avalon-mm slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// port settings from the gpio block
	input wire [NPIN-1:0] port_dir_out,
	input wire [NPIN-1:0] port_pullup_en,
	// pin function controls
	output reg [NPIN-1:0] pin_analog_en_q,
	output reg [NPIN-1:0] pin_digital_off_q,
	output reg [NPIN-1:0] pin_out_en_mask_q,
	output reg [NPIN-1:0] pin_pullup_q,
	// analog front end controls
	output reg [2:0] mux_route_q,
	output reg [1:0] mux_ratio_q,
	output reg [2:0] ext_chan_q,
	output reg ext_chan_on_q,
	output reg [1:0] ref_sel_q,
	output reg amp_in_sel_q,
	output reg conv_power_q,
	output reg sample_q,
	output reg sar_step_q,
	output reg conv_clk_en_q,
	// successive approximation comparator, asynchronous
	input wire sar_cmp,
	// interrupt line
	output reg irq_q
);
	reg [7:0] ctrl0_q;
	reg [7:0] ctrl1_q;
	reg [7:0] ctrl2_q;
	reg [NPIN-1:0] pinsel_q;
	reg gie_q;
	reg aie_q;
	reg flag_q;
	reg busy_q;
	reg [6:0] div_cnt_q;
	reg [3:0] step_q;
	reg [RW-1:0] sar_q;
	reg cmp_s1_q;
	reg cmp_s2_q;
	reg res_wr_q;
	reg rd_pend_q;
	reg rd_res_q;
	reg [1:0] state_q;
	wire res_addr;
	wire [7:0] res_byte;
	wire cs_strobe;
	wire start_fall;
	wire conv_tick;
	wire done_evt;
	wire [3:0] src;
	wire [3:0] chan;
	localparam ST_IDLE = 2'b00;
	localparam ST_SAMPLE = 2'b01;
	localparam ST_CONV = 2'b10;
	localparam [3:0] SMP_LAST = `ADCS_SAMPLE_CLKS - 1;
	localparam [3:0] CNV_LAST = `ADCS_CONV_CLKS - 1;

	// divider mask: code n means divide by 2**n
	function [6:0] div_mask;
		input [2:0] code;
		begin
			div_mask = 7'h7f >> (3'd7 - code);
		end
	endfunction

	assign src = ctrl1_q[`ADCS_C1_SRC_LSB +: 4];
	assign chan = ctrl0_q[`ADCS_C0_CS_LSB +: 4];
	assign cs_strobe = avs_write && avs_waitrequest == 1'b0;
	assign res_addr = avs_address == `ADCS_ADDR_RES_HI || avs_address == `ADCS_ADDR_RES_LO;
	assign start_fall = cs_strobe && avs_address == `ADCS_ADDR_CTRL0 &&
		ctrl0_q[`ADCS_C0_START] && !avs_writedata[`ADCS_C0_START];
	assign conv_tick = (div_cnt_q & div_mask(ctrl1_q[`ADCS_C1_DIV_LSB +: 3])) == 7'h00;
	assign done_evt = state_q == ST_CONV && conv_tick && step_q == 4'h0;

	// waitrequest: one wait cycle, a second one for result reads behind the memory
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else if (rd_res_q || (avs_write || (avs_read && !res_addr)) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// register writes and the flag state
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0_q <= 8'h00;
			ctrl1_q <= `ADCS_RST_CTRL1;
			ctrl2_q <= 8'h00;
			pinsel_q <= {NPIN{1'b0}};
			gie_q <= 1'b0;
			aie_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			if (cs_strobe) begin
				case (avs_address)
					`ADCS_ADDR_CTRL0: ctrl0_q <= avs_writedata[7:0];
					`ADCS_ADDR_CTRL1: ctrl1_q <= avs_writedata[7:0];
					`ADCS_ADDR_CTRL2: ctrl2_q <= avs_writedata[7:0];
					`ADCS_ADDR_PINSEL: pinsel_q <= avs_writedata[NPIN-1:0];
					`ADCS_ADDR_INTC: begin
						gie_q <= avs_writedata[`ADCS_IC_GIE];
						aie_q <= avs_writedata[`ADCS_IC_AIE];
						flag_q <= avs_writedata[`ADCS_IC_FLAG];
					end
					default: ;
				endcase
			end
			// completion sets flag, set beats clear
			if (done_evt) begin
				flag_q <= 1'b1;
			end
		end
	end

	// conversion sequencer on converter clock ticks
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
			step_q <= 4'h0;
			div_cnt_q <= 7'h00;
			sar_q <= {RW{1'b0}};
			res_wr_q <= 1'b0;
		end else begin
			res_wr_q <= 1'b0;
			div_cnt_q <= div_cnt_q + 7'h01;
			case (state_q)
				ST_IDLE: begin
					// busy set with the falling edge
					if (start_fall && conv_power_q) begin
						state_q <= ST_SAMPLE;
						busy_q <= 1'b1;
						step_q <= SMP_LAST;
						div_cnt_q <= 7'h01;
						sar_q <= {RW{1'b0}};
					end
				end
				ST_SAMPLE: begin
					if (conv_tick) begin
						if (step_q == 4'h0) begin
							state_q <= ST_CONV;
							step_q <= CNV_LAST;
						end else begin
							step_q <= step_q - 4'h1;
						end
					end
				end
				ST_CONV: begin
					// twelve conversion clocks, one bit each
					if (conv_tick) begin
						sar_q[step_q] <= cmp_s2_q;
						if (step_q == 4'h0) begin
							state_q <= ST_IDLE;
							busy_q <= 1'b0;
							res_wr_q <= 1'b1;
						end else begin
							step_q <= step_q - 4'h1;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// comparator synchroniser
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			cmp_s1_q <= sar_cmp;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	adcs_result_mem #(
		.DW(8)
	) u_res (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.wr_en(res_wr_q),
		.wr_hi(ctrl0_q[`ADCS_C0_FMT] ? {4'h0, sar_q[11:8]} : sar_q[11:4]),
		.wr_lo(ctrl0_q[`ADCS_C0_FMT] ? sar_q[7:0] : {sar_q[3:0], 4'h0}),
		.rd_sel_hi(avs_address == `ADCS_ADDR_RES_HI),
		.rd_data_q(res_byte)
	);

	// read path: result bytes land one cycle later, so they win over the decode
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h00000000;
		end else if (rd_res_q) begin
			avs_readdata <= {24'h000000, res_byte};
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				`ADCS_ADDR_CTRL0: avs_readdata <= {24'h000000, ctrl0_q[7],
					busy_q, ctrl0_q[5:0]};
				`ADCS_ADDR_CTRL1: avs_readdata <= {24'h000000, ctrl1_q};
				`ADCS_ADDR_CTRL2: avs_readdata <= {24'h000000, ctrl2_q};
				`ADCS_ADDR_PINSEL: avs_readdata <= {{(32-NPIN){1'b0}}, pinsel_q};
				`ADCS_ADDR_INTC: avs_readdata <= {29'h00000000, flag_q, aie_q, gie_q};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// mark result reads to pick up the registered memory output
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_res_q <= 1'b0;
		end else begin
			// one pulse per result read, then waitrequest drops
			rd_res_q <= avs_read && avs_waitrequest && res_addr && !rd_res_q;
		end
	end

	// analog routing and pin controls, all registered outputs
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mux_route_q <= `ADCS_RT_EXT;
			mux_ratio_q <= 2'b00;
			ext_chan_q <= 3'h0;
			ext_chan_on_q <= 1'b0;
			pin_analog_en_q <= {NPIN{1'b0}};
			pin_digital_off_q <= {NPIN{1'b0}};
			pin_out_en_mask_q <= {NPIN{1'b0}};
			pin_pullup_q <= {NPIN{1'b0}};
			ref_sel_q <= 2'b00;
			amp_in_sel_q <= 1'b0;
			conv_power_q <= 1'b0;
			sample_q <= 1'b0;
			sar_step_q <= 1'b0;
			conv_clk_en_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ext_chan_q <= chan[2:0];
			ext_chan_on_q <= 1'b0;
			mux_ratio_q <= 2'b00;
			case (src)
				4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: begin
					mux_route_q <= chan[3] ? `ADCS_RT_FLOAT : `ADCS_RT_EXT;
					ext_chan_on_q <= !chan[3];
				end
				4'h1, 4'h2, 4'h3: begin
					mux_route_q <= `ADCS_RT_AVDD;
					mux_ratio_q <= src[1:0] - 2'b01;
				end
				4'h5, 4'h6, 4'h7: begin
					mux_route_q <= `ADCS_RT_PGA;
					mux_ratio_q <= src[1:0] - 2'b01;
				end
				4'h8: mux_route_q <= `ADCS_RT_PROX0;
				4'h9: mux_route_q <= `ADCS_RT_PROX1;
				default: mux_route_q <= `ADCS_RT_GND;
			endcase
			pin_analog_en_q <= pinsel_q;
			pin_digital_off_q <= pinsel_q;
			pin_out_en_mask_q <= port_dir_out & ~pinsel_q;
			pin_pullup_q <= port_pullup_en & ~pinsel_q;
			ref_sel_q <= ctrl2_q[`ADCS_C2_VRS_LSB +: 2];
			amp_in_sel_q <= ctrl2_q[`ADCS_C2_AMPLIFIER_INPUT_SELECT];
			conv_power_q <= ctrl0_q[`ADCS_C0_PWR];
			sample_q <= state_q == ST_SAMPLE;
			sar_step_q <= state_q == ST_CONV && conv_tick;
			conv_clk_en_q <= conv_tick;
			irq_q <= flag_q && gie_q && aie_q;
		end
	end
endmodule // adcs_top

// >>> tb/adcs_chk.sv
// port checker for the converter sequencer
`timescale 1ns/1ps
module adcs_chk #(
	parameter NPIN = 8
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// register bus
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// pins
	input wire [NPIN-1:0] port_dir_out,
	input wire [NPIN-1:0] port_pullup_en,
	input wire [NPIN-1:0] pin_analog_en_q,
	input wire [NPIN-1:0] pin_out_en_mask_q,
	input wire [NPIN-1:0] pin_pullup_q,
	// converter
	input wire [2:0] mux_route_q,
	input wire [1:0] mux_ratio_q,
	input wire ext_chan_on_q,
	input wire conv_power_q,
	input wire sample_q,
	input wire sar_step_q
);
	logic [3:0] step_cnt_q;
	logic seen_q;
	// steps since sampling ended; first conversion has nothing before it
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			step_cnt_q <= 4'h0;
			seen_q <= 1'b0;
		end else if (sample_q) begin
			step_cnt_q <= 4'h0;
			seen_q <= 1'b1;
		end else if (sar_step_q) begin
			step_cnt_q <= step_cnt_q + 4'h1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// bus answer shape
	property p_wait_one;
		$fell(avs_waitrequest) |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address > 4'h6 |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// pin overrides, once inputs have settled
	property p_pull;
		$past(rst_b) && $stable(pin_analog_en_q) && $stable(port_pullup_en)
			|-> pin_pullup_q == (port_pullup_en & ~pin_analog_en_q);
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up on analog pin");
	property p_dir;
		$past(rst_b) && $stable(pin_analog_en_q) && $stable(port_dir_out)
			|-> pin_out_en_mask_q == (port_dir_out & ~pin_analog_en_q);
	endproperty
	a_dir: assert property (p_dir) else $error("drive on analog pin");
	// source routing
	property p_ratio;
		mux_route_q != 3'h1 && mux_route_q != 3'h2 |-> mux_ratio_q == 2'h0;
	endproperty
	a_ratio: assert property (p_ratio) else $error("ratio on unscaled route");
	property p_ext;
		ext_chan_on_q |-> mux_route_q == 3'h0;
	endproperty
	a_ext: assert property (p_ext) else $error("channel on with internal route");
	// power bit follows a control write two edges on
	property p_pwr;
		avs_write && !avs_waitrequest && avs_address == 4'h0
			|-> ##2 conv_power_q == $past(avs_writedata[5], 2);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit not applied");
	// twelve conversion steps per conversion
	property p_steps;
		$rose(sample_q) && seen_q |-> step_cnt_q == 4'hc;
	endproperty
	a_steps: assert property (p_steps) else $error("wrong step count");
endmodule // adcs_chk

// >>> tb/adcs_top_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "adcs_consts.vh"
module adcs_top_tb;
	logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, sar_cmp;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [7:0] port_dir_out, port_pullup_en, an_en, dig_off, oe_mask, pull;
	logic [2:0] route, ext_chan, e_rt;
	logic [1:0] ratio, ref_sel;
	logic ext_on, amp_in, pwr, sample, step, cke, irq;
	logic [11:0] r;
	integer err_count = 0, n_checks = 0, cyc = 0, t0, k, n, c;
	// 200 MHz clock and a cycle count
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;
	adcs_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.port_dir_out(port_dir_out), .port_pullup_en(port_pullup_en), .pin_analog_en_q(an_en),
		.pin_digital_off_q(dig_off), .pin_out_en_mask_q(oe_mask), .pin_pullup_q(pull),
		.mux_route_q(route), .mux_ratio_q(ratio), .ext_chan_q(ext_chan), .ext_chan_on_q(ext_on),
		.ref_sel_q(ref_sel), .amp_in_sel_q(amp_in), .conv_power_q(pwr), .sample_q(sample),
		.sar_step_q(step), .conv_clk_en_q(cke), .sar_cmp(sar_cmp), .irq_q(irq));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one access, held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		integer i;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= ~w;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 40);
		if (avs_waitrequest !== 1'b0) chk(32'h1, 32'h0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [3:0] a);
		bus(1'b0, a, 8'h0);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard, far beyond the longest conversion sweep
	initial begin
		#300000;
		err_count++;
		close_out;
	end
	initial begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		sar_cmp = 1'b0;
		port_dir_out = 8'hff;
		port_pullup_en = 8'hff;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		// reset value, unmapped write then read
		rd(`ADCS_ADDR_CTRL1);
		chk(q, {24'h0, `ADCS_RST_CTRL1});
		wr(4'hf, 8'h5a);
		rd(4'hf);
		chk(q, 32'h0);
		$display("test reset done");
		// analog pins lose pull-up, drive and digital use
		port_pullup_en <= 8'h3c;
		wr(`ADCS_ADDR_PINSEL, 8'h0f);
		wr(`ADCS_ADDR_CTRL2, 8'h06);
		repeat (3) @(posedge clk_sys);
		chk(an_en, 8'h0f);
		chk(dig_off, 8'h0f);
		chk(ref_sel, 2'h2);
		chk(amp_in, 1'b1);
		chk(pull, 8'h30);
		chk(oe_mask, 8'hf0);
		$display("test pins done");
		// every source code; odd codes carry a missing channel
		for (c = 0; c < 16; c++) begin
			wr(`ADCS_ADDR_CTRL0, {4'h2, c[0], 3'h5});
			wr(`ADCS_ADDR_CTRL1, {c[3:0], 4'h0});
			repeat (3) @(posedge clk_sys);
			e_rt = (c > 0 && c < 4) ? `ADCS_RT_AVDD : (c > 4 && c < 8) ? `ADCS_RT_PGA :
				(c == 8) ? `ADCS_RT_PROX0 : (c == 9) ? `ADCS_RT_PROX1 :
				(c == 10 || c == 11) ? `ADCS_RT_GND : c[0] ? `ADCS_RT_FLOAT : `ADCS_RT_EXT;
			chk(route, e_rt);
			chk(ratio, (e_rt == 3'h1 || e_rt == 3'h2) ? c[1:0] - 2'h1 : 2'h0);
			chk(ext_on, e_rt == `ADCS_RT_EXT);
			chk(ext_chan, 3'h5);
			chk(cke, 1'b1);
		end
		$display("test sources done");
		// start with power off is ignored
		wr(`ADCS_ADDR_CTRL0, 8'h80);
		wr(`ADCS_ADDR_CTRL0, 8'h00);
		rd(`ADCS_ADDR_CTRL0);
		chk(q[6], 1'b0);
		$display("test power off done");
		wr(`ADCS_ADDR_CTRL0, 8'h20);
		// every divider, both formats, interrupt on and off
		for (n = 0; n < 8; n++) begin
			sar_cmp <= n[0];
			wr(`ADCS_ADDR_CTRL1, {5'h0, n[2:0]});
			wr(`ADCS_ADDR_INTC, {6'h0, ~n[2], 1'b1});
			wr(`ADCS_ADDR_CTRL0, {3'b101, n[1], 4'h0});
			wr(`ADCS_ADDR_CTRL0, {3'b001, n[1], 4'h0});
			t0 = cyc;
			rd(`ADCS_ADDR_CTRL0);
			chk(q[6], 1'b1);
			k = 0;
			while (q[6] === 1'b1 && k < 2000) begin
				rd(`ADCS_ADDR_CTRL0);
				k++;
			end
			chk(cyc - t0 >= (16 << n) - 2 && cyc - t0 <= (16 << n) + 8, 1'b1);
			r = n[0] ? 12'hfff : 12'h000;
			rd(`ADCS_ADDR_RES_HI);
			chk(q, n[1] ? {28'h0, r[11:8]} : {24'h0, r[11:4]});
			rd(`ADCS_ADDR_RES_LO);
			chk(q, n[1] ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0});
			rd(`ADCS_ADDR_INTC);
			chk(q[2], 1'b1);
			chk(irq, !n[2]);
			wr(`ADCS_ADDR_INTC, 8'h03);
			repeat (2) @(posedge clk_sys);
			chk(irq, 1'b0);
			$display("test conversion %0d done", n);
		end
		close_out;
	end
endmodule // adcs_top_tb
bind adcs_top adcs_chk #(.NPIN(NPIN)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .port_dir_out(port_dir_out),
	.port_pullup_en(port_pullup_en), .pin_analog_en_q(pin_analog_en_q),
	.pin_out_en_mask_q(pin_out_en_mask_q), .pin_pullup_q(pin_pullup_q),
	.mux_route_q(mux_route_q), .mux_ratio_q(mux_ratio_q), .ext_chan_on_q(ext_chan_on_q),
	.conv_power_q(conv_power_q), .sample_q(sample_q), .sar_step_q(sar_step_q));
